// ==== hdl/acs_sched.sv ====
// Calibration scheduler: timing, policy, inhibits and status
//
// Notes on behaviour
// - First cycle 0.2 s after power-up, then two minutes after the last completed cycle.
// - Front-panel preset calibrates after 2 s, remote preset at once.
// - Center, manual frequency, bandwidth or impedance change triggers a cycle.
// - Front-panel changes wait 2 s, except in manual mode: immediate.
// - Remote parameter changes calibrate immediately.
// - Tuned below 150 kHz, a parameter change triggers a cycle only by aborting a running one.
// - Continuous knob changes of manual frequency trigger nothing outside a cycle; during one they abort it.
// - Forced calibration accepted any time and starts a cycle.
// - In-progress indication shown while a cycle runs.
// - Failure sounds beeper and shows numbered error code.
// - Calibrate at tuned frequency, or 150 kHz when tuned lower.
// - Reference source into terminated input, dummy load across it.
// - Always calibrate via terminated input, whatever input selected.
// - Remote entries refused during a cycle; front panel still accepted.
// - Front-panel parameter change during a cycle aborts it; new one 2 s later.
// - Running cycle inhibits measurement, auto functions, halts sweep.
// - Periodic cycle waits for sweep end unless sweep >= 22 s.
// - Normal cycle waits while noise-level calculation runs.
// - Disable/enable command; disabled due cycles show disabled indication.
// - Video and IF outputs held full-scale during a cycle.
module acs_sched #(
  parameter logic [acs_pkg::CNT_W-1:0] POWERUP_CYC = acs_pkg::POWERUP_CYC,
  parameter logic [acs_pkg::CNT_W-1:0] DELAY_CYC   = acs_pkg::DELAY_CYC,
  parameter logic [acs_pkg::CNT_W-1:0] PERIOD_CYC  = acs_pkg::PERIOD_CYC
) (
  // Clock and reset
  input  logic                        core_clk,
  input  logic                        srst,
  // Operator and controller commands
  input  logic                        preset_front,
  input  logic                        preset_remote,
  input  logic                        force_cal,
  input  logic                        cal_disable,
  input  logic                        cal_enable,
  input  logic                        remote_entry,
  // Tuning parameter changes
  input  logic                        param_change,
  input  logic                        param_remote,
  input  logic                        param_knob,
  input  logic                        manual_mode,
  input  logic [acs_pkg::FREQ_W-1:0]  tuned_freq,
  // Measurement state
  input  logic                        sweep_active,
  input  logic [acs_pkg::SWEEP_W-1:0] sweep_time_ms,
  input  logic                        noise_busy,
  // Calibration engine
  input  logic                        cal_done,
  input  logic                        cal_fail,
  input  logic [acs_pkg::ERR_W-1:0]   cal_err_code,
  output logic                        cal_start,
  output logic                        cal_abort,
  output logic [acs_pkg::FREQ_W-1:0]  cal_freq,
  // Input path switching
  output logic                        ref_to_term,
  output logic                        dummy_load_on,
  // Inhibits and analog outputs
  output logic                        meas_inhibit,
  output logic                        sweep_halt,
  output logic                        video_full_scale,
  output logic                        if_full_scale,
  // Remote entry answer
  output logic                        remote_accept,
  output logic                        remote_refused,
  // Operator display and beeper
  output logic                        calibration_in_progress_indication,
  output logic                        cal_disabled_ind,
  output logic                        beep,
  output logic                        err_show,
  output logic [acs_pkg::ERR_W-1:0]   err_code
);
  import acs_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  acs_state_e state_r;
  acs_state_e state_nxt;
  logic       run_r;
  logic       en_r;
  logic       due_norm_r;
  logic       due_prio_r;
  logic       force_r;
  logic       dly_norm_r;
  logic       period_exp;
  logic       dly_exp;
  logic       dly_load;
  logic       any_due;
  logic       may_run;
  logic       held;
  logic       go;
  logic       skip;
  logic       start;
  logic       done;
  logic       abort;
  logic       long_sweep;

  acs_trig_if trig_bus ();

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  // Parameter change qualifier
  acs_trig u_trig (
    .core_clk     (core_clk),
    .srst         (srst),
    .param_change (param_change),
    .param_remote (param_remote),
    .param_knob   (param_knob),
    .manual_mode  (manual_mode),
    .tuned_freq   (tuned_freq),
    .cal_running  (run_r),
    .trig         (trig_bus.src)
  );

  // Power-up then periodic interval timer
  acs_delay #(.INIT(POWERUP_CYC)) u_period (
    .core_clk (core_clk),
    .srst     (srst),
    .load     (period_exp || done),
    .load_val (PERIOD_CYC),
    .cancel   (1'b0),
    .expire   (period_exp),
    .active   ()
  );

  // Two-second delay for front-panel presets, front-panel changes and aborts
  assign dly_load = preset_front || trig_bus.delay_req || abort;
  acs_delay #(.INIT('0)) u_delay (
    .core_clk (core_clk),
    .srst     (srst),
    .load     (dly_load),
    .load_val (DELAY_CYC),
    .cancel   (1'b0),
    .expire   (dly_exp),
    .active   ()
  );

  // ------------------------------------------------------------
  // Scheduling decision
  // ------------------------------------------------------------
  // Hold-offs only apply to normal (periodic or front preset) cycles
  assign long_sweep = (sweep_time_ms >= LONG_SWEEP_MS);
  assign any_due    = due_norm_r || due_prio_r;
  assign may_run    = en_r || force_r;
  assign held       = due_norm_r && !due_prio_r
                      && (noise_busy
                          || (sweep_active && !long_sweep));
  assign go         = any_due && may_run && !held;
  assign skip       = any_due && !may_run;
  assign start      = !run_r && go;
  assign done       = run_r && cal_done;
  assign abort      = run_r && trig_bus.abort_req;

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (done || abort) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE, ST_HOLD: begin
        if (go) begin
          state_nxt = ST_RUN;
        end else if (any_due && !skip) begin
          state_nxt = ST_HOLD;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      run_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      run_r   <= (state_nxt == ST_RUN);
    end
  end

  // ------------------------------------------------------------
  // Pending requests
  // ------------------------------------------------------------
  // Which class the delay timer will raise when it expires
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dly_norm_r <= 1'b0;
    end else if (trig_bus.delay_req || abort) begin
      dly_norm_r <= 1'b0;
    end else if (preset_front) begin
      dly_norm_r <= 1'b1;
    end
  end

  // Due flags; a new request wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      due_norm_r <= 1'b0;
      due_prio_r <= 1'b0;
      force_r    <= 1'b0;
    end else begin
      due_norm_r <= (due_norm_r && !(start || skip || done))
                    || period_exp
                    || (dly_exp && dly_norm_r);
      due_prio_r <= (due_prio_r && !(start || skip))
                    || trig_bus.now_req
                    || preset_remote
                    || force_cal
                    || (cal_enable && !en_r)
                    || (dly_exp && !dly_norm_r);
      force_r    <= (force_r && !start) || force_cal;
    end
  end

  // Enable flag
  always_ff @(posedge core_clk) begin
    if (srst) begin
      en_r <= 1'b1;
    end else if (cal_enable) begin
      en_r <= 1'b1;
    end else if (cal_disable) begin
      en_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Engine handshake and cycle outputs
  // ------------------------------------------------------------
  // Start and abort pulses, calibration frequency
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cal_start <= 1'b0;
      cal_abort <= 1'b0;
      cal_freq  <= MIN_CAL_FREQ_HZ;
    end else begin
      cal_start <= start;
      cal_abort <= abort;
      if (start) begin
        cal_freq <= freq_ok(tuned_freq) ? tuned_freq
                                        : MIN_CAL_FREQ_HZ;
      end
    end
  end

  // Everything that follows the running cycle
  assign calibration_in_progress_indication = run_r;
  assign ref_to_term      = run_r;
  assign dummy_load_on    = run_r;
  assign meas_inhibit     = run_r;
  assign sweep_halt       = run_r;
  assign video_full_scale = run_r;
  assign if_full_scale    = run_r;

  // Remote entry answer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      remote_accept  <= 1'b0;
      remote_refused <= 1'b0;
    end else begin
      remote_accept  <= remote_entry && !run_r;
      remote_refused <= remote_entry && run_r;
    end
  end

  // ------------------------------------------------------------
  // Operator status
  // ------------------------------------------------------------
  // Disabled indication and error report
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cal_disabled_ind <= 1'b0;
      beep             <= 1'b0;
      err_show         <= 1'b0;
      err_code         <= ERR_NONE;
    end else begin
      beep <= done && cal_fail;
      if (skip) begin
        cal_disabled_ind <= 1'b1;
      end else if (start || cal_enable) begin
        cal_disabled_ind <= 1'b0;
      end
      if (done) begin
        err_show <= cal_fail;
        if (cal_fail) begin
          err_code <= cal_err_code;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence s_fail_seen;
    run_r && cal_done && cal_fail;
  endsequence

  sequence s_fail_shown;
    beep && err_show && (err_code == $past(cal_err_code));
  endsequence

  a_start_shows_run: assert property (
    cal_start |-> calibration_in_progress_indication && meas_inhibit)
    else $error("start without in-progress indication");

  a_fail_report: assert property (
    s_fail_seen |=> s_fail_shown ##1 (!beep && err_show))
    else $error("failure not reported");

  a_cal_freq_floor: assert property (
    cal_start |-> cal_freq >= MIN_CAL_FREQ_HZ)
    else $error("calibration frequency below floor");

  a_remote_refused: assert property (
    remote_entry && run_r |=> remote_refused && !remote_accept)
    else $error("remote entry not refused during cycle");

  a_abort_cycle: assert property (
    run_r && trig_bus.abort_req |=> cal_abort && !run_r)
    else $error("parameter change did not abort cycle");

  a_noise_hold: assert property (
    !run_r && due_norm_r && !due_prio_r && noise_busy |=> !run_r)
    else $error("normal cycle ran during noise calculation");

  a_sweep_hold: assert property (
    !run_r && due_norm_r && !due_prio_r && sweep_active && !long_sweep
    |=> !run_r)
    else $error("periodic cycle broke a short sweep");

  a_disabled_skip: assert property (
    !run_r && any_due && !en_r && !force_r
    |=> cal_disabled_ind && !run_r)
    else $error("disabled cycle not indicated");

  a_force_runs: assert property (
    force_cal && !run_r && !noise_busy |=> ##[0:2] run_r)
    else $error("forced calibration did not start");

endmodule

// ==== hdl/acs_pkg.sv ====
// Constants, types and helpers shared by the calibration scheduler
package acs_pkg;

  // ------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------
  localparam int     CNT_W     = 33;
  localparam longint CLK_HZ    = 50_000_000;
  localparam longint MS_PER_S  = 1000;
  localparam longint POWERUP_MS = 200;
  localparam longint DELAY_MS  = 2000;
  localparam longint PERIOD_MS = 120_000;

  // Cycle counts derived from the times above
  localparam logic [CNT_W-1:0] POWERUP_CYC =
    CNT_W'(POWERUP_MS * CLK_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] DELAY_CYC =
    CNT_W'(DELAY_MS * CLK_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] PERIOD_CYC =
    CNT_W'(PERIOD_MS * CLK_HZ / MS_PER_S);
  localparam logic [CNT_W-1:0] CNT_ONE = 33'h0_0000_0001;

  // ------------------------------------------------------------
  // Tuning, sweep and error widths
  // ------------------------------------------------------------
  localparam int FREQ_W  = 32;
  localparam int SWEEP_W = 32;
  localparam int ERR_W   = 8;
  localparam logic [FREQ_W-1:0]  MIN_CAL_FREQ_HZ = 32'h0002_49F0;
  localparam logic [SWEEP_W-1:0] LONG_SWEEP_MS   = 32'h0000_55F0;
  localparam logic [ERR_W-1:0]   ERR_NONE        = 8'h00;

  // Scheduler states
  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_RUN} acs_state_e;

  // Frequency high enough to calibrate at itself
  function automatic logic freq_ok(input logic [FREQ_W-1:0] f);
    freq_ok = (f >= MIN_CAL_FREQ_HZ);
  endfunction

endpackage

// ==== hdl/acs_trig_if.sv ====
// Trigger requests passed from the parameter qualifier to the scheduler
interface acs_trig_if;
  logic now_req;
  logic delay_req;
  logic abort_req;
  modport src (output now_req, output delay_req, output abort_req);
  modport dst (input now_req, input delay_req, input abort_req);
endinterface

// ==== hdl/acs_delay.sv ====
// One-shot countdown timer with a registered expiry pulse
module acs_delay #(
  parameter logic [acs_pkg::CNT_W-1:0] INIT = '0
) (
  // Clock and reset
  input  logic                      core_clk,
  input  logic                      srst,
  // Control
  input  logic                      load,
  input  logic [acs_pkg::CNT_W-1:0] load_val,
  input  logic                      cancel,
  // Status
  output logic                      expire,
  output logic                      active
);
  import acs_pkg::*;

  logic [CNT_W-1:0] cnt_r;

  // Count down, pulse on reaching the end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_r  <= INIT;
      active <= (INIT != '0);
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (load) begin
        cnt_r  <= load_val;
        active <= 1'b1;
      end else if (cancel) begin
        active <= 1'b0;
      end else if (active) begin
        if (cnt_r <= CNT_ONE) begin
          active <= 1'b0;
          expire <= 1'b1;
        end else begin
          cnt_r <= cnt_r - CNT_ONE;
        end
      end
    end
  end

endmodule

// ==== hdl/acs_trig.sv ====
// Qualifies tuning parameter changes into calibration requests
module acs_trig (
  // Clock and reset
  input  logic                       core_clk,
  input  logic                       srst,
  // Parameter change event
  input  logic                       param_change,
  input  logic                       param_remote,
  input  logic                       param_knob,
  input  logic                       manual_mode,
  input  logic [acs_pkg::FREQ_W-1:0] tuned_freq,
  input  logic                       cal_running,
  // Requests to the scheduler
  acs_trig_if.src                    trig
);
  import acs_pkg::*;

  logic taken;
  logic trig_ok;
  logic now_c;

  // Remote changes are refused while a cycle runs
  assign taken   = param_change && !(param_remote && cal_running);
  assign trig_ok = taken && !param_knob
                   && freq_ok(tuned_freq);
  assign now_c   = trig_ok && !cal_running
                   && (param_remote || manual_mode);

  // Registered requests
  always_ff @(posedge core_clk) begin
    if (srst) begin
      trig.now_req   <= 1'b0;
      trig.delay_req <= 1'b0;
      trig.abort_req <= 1'b0;
    end else begin
      trig.now_req   <= now_c;
      trig.delay_req <= trig_ok && !now_c;
      trig.abort_req <= taken && cal_running;
    end
  end

  a_knob_no_trig: assert property (@(posedge core_clk) disable iff (srst)
    param_change && param_knob |=> !trig.now_req && !trig.delay_req)
    else $error("continuous entry triggered a calibration");

  a_remote_now: assert property (@(posedge core_clk) disable iff (srst)
    param_change && param_remote && !cal_running && !param_knob
    && freq_ok(tuned_freq) |=> trig.now_req && !trig.delay_req)
    else $error("remote change did not calibrate at once");

endmodule

// ==== verif/acs_engine_model.sv ====
// Behavioural calibration engine that answers start and abort
module acs_engine_model (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  // Behaviour chosen by the bench
  input  wire logic [31:0]               dly,
  input  wire logic                      fail_next,
  input  wire logic [acs_pkg::ERR_W-1:0] code_next,
  // Engine handshake
  input  wire logic                      cal_start,
  input  wire logic                      cal_abort,
  output logic                           cal_done,
  output logic                           cal_fail,
  output logic [acs_pkg::ERR_W-1:0]      cal_err_code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt_r;
  logic        busy_r;
  logic        fin;

  // Last cycle of a cycle that was not aborted
  assign fin = busy_r && !cal_abort && (cnt_r <= 32'h0000_0001);

  // Countdown of one cycle's length, cut short by an abort
  always_ff @(posedge core_clk) begin
    if (srst) begin
      busy_r <= 1'b0;
      cnt_r <= 32'h0000_0000;
    end else if (cal_start) begin
      busy_r <= 1'b1;
      cnt_r <= dly;
    end else if (cal_abort || fin) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 32'h0000_0001;
    end
  end

  // Done pulse; result lines scramble while they carry nothing
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cal_done <= 1'b0;
      cal_fail <= 1'b0;
      cal_err_code <= '0;
    end else begin
      cal_done <= fin;
      cal_fail <= fin ? fail_next : ~cal_fail;
      cal_err_code <= fin ? code_next : ~cal_err_code;
    end
  end
endmodule

// ==== verif/acs_sched_tb_top.sv ====
// Self-checking bench for the calibration scheduler
module acs_sched_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  localparam int PU = 20;
  localparam int DL = 30;
  localparam int PD = 200;
  localparam int P_FRONT = 0, P_REM = 1, P_FORCE = 2, P_DIS = 3;
  localparam int P_EN = 4, P_ENTRY = 5, P_CHG = 6;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [6:0] pulse_r = 7'h00;
  logic param_remote = 1'b0, param_knob = 1'b0, manual_mode = 1'b0;
  logic [FREQ_W-1:0] tuned_freq = 32'h000F_4240;
  logic sweep_active = 1'b0, noise_busy = 1'b0;
  logic [SWEEP_W-1:0] sweep_time_ms = 32'h0000_0064;
  logic cal_done, cal_fail, cal_start, cal_abort;
  logic [ERR_W-1:0] cal_err_code, err_code;
  logic [ERR_W-1:0] code_next = 8'h00;
  logic fail_next = 1'b0;
  logic [31:0] dly = 32'h0000_0005;
  logic [FREQ_W-1:0] cal_freq;
  logic ref_to_term, dummy_load_on, meas_inhibit, sweep_halt;
  logic video_full_scale, if_full_scale, remote_accept, remote_refused;
  logic calibration_in_progress_indication, cal_disabled_ind, beep;
  logic err_show;
  logic [6:0] run_vec;
  int miscompares = 0, comparisons = 0, starts = 0, beeps = 0;
  int n, s0, b0;
  logic [ERR_W-1:0] code;

  assign run_vec = {ref_to_term, dummy_load_on, meas_inhibit, sweep_halt,
                    video_full_scale, if_full_scale,
                    calibration_in_progress_indication};

  acs_sched #(
    .POWERUP_CYC (33'h0_0000_0014),
    .DELAY_CYC   (33'h0_0000_001E),
    .PERIOD_CYC  (33'h0_0000_00C8)
  ) acs_sched_inst (
    .core_clk(core_clk), .srst(srst),
    .preset_front(pulse_r[P_FRONT]), .preset_remote(pulse_r[P_REM]),
    .force_cal(pulse_r[P_FORCE]), .cal_disable(pulse_r[P_DIS]),
    .cal_enable(pulse_r[P_EN]), .remote_entry(pulse_r[P_ENTRY]),
    .param_change(pulse_r[P_CHG]), .param_remote(param_remote),
    .param_knob(param_knob), .manual_mode(manual_mode),
    .tuned_freq(tuned_freq), .sweep_active(sweep_active),
    .sweep_time_ms(sweep_time_ms), .noise_busy(noise_busy),
    .cal_done(cal_done), .cal_fail(cal_fail), .cal_err_code(cal_err_code),
    .cal_start(cal_start), .cal_abort(cal_abort), .cal_freq(cal_freq),
    .ref_to_term(ref_to_term), .dummy_load_on(dummy_load_on),
    .meas_inhibit(meas_inhibit), .sweep_halt(sweep_halt),
    .video_full_scale(video_full_scale), .if_full_scale(if_full_scale),
    .remote_accept(remote_accept), .remote_refused(remote_refused),
    .calibration_in_progress_indication(calibration_in_progress_indication),
    .cal_disabled_ind(cal_disabled_ind), .beep(beep),
    .err_show(err_show), .err_code(err_code));

  acs_engine_model acs_engine_model_inst (
    .core_clk(core_clk), .srst(srst), .dly(dly), .fail_next(fail_next),
    .code_next(code_next), .cal_start(cal_start), .cal_abort(cal_abort),
    .cal_done(cal_done), .cal_fail(cal_fail), .cal_err_code(cal_err_code));

  // Clock source
  initial begin
    forever #10 core_clk = ~core_clk;
  end

  // Counts of start pulses and beeper cycles
  always @(posedge core_clk) begin
    if (cal_start === 1'b1) starts++;
    if (beep === 1'b1) beeps++;
  end

  // Comparison with report on mismatch
  task automatic check(input string name, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk_true(input string name, input bit cond);
    check(name, {31'h0, cond}, 32'h1);
  endtask

  // One-cycle command pulse; returns at the edge that samples it
  task automatic fire(input int k);
    @(posedge core_clk);
    pulse_r <= 7'(1 << k);
    @(posedge core_clk);
    pulse_r <= 7'h00;
  endtask

  // Edges until a start pulse, run outputs checked when it comes
  task automatic wait_start(input int lim, output int cnt);
    cnt = 0;
    #1;
    while (cal_start !== 1'b1 && cnt < lim) begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
    if (cal_start === 1'b1)
      check("run_outputs", {25'h0, run_vec}, 32'h7F);
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (calibration_in_progress_indication !== 1'b0 && k < 300) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk_true("cycle_ends", k < 300);
  endtask

  task automatic quiet(input int cyc, input string name);
    s0 = starts;
    repeat (cyc) @(posedge core_clk);
    #1;
    check(name, 32'(starts), 32'(s0));
  endtask

  task automatic print_verdict();
    $display("counts: comparisons %0d miscompares %0d", comparisons,
             miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog against a hung scheduler
  initial begin
    repeat (20000) @(posedge core_clk);
    $display("watchdog expired");
    miscompares++;
    print_verdict();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h0DFB78EE));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    wait_start(PU + 10, n);
    chk_true("powerup_delay", n >= PU && n <= PU + 3);
    check("powerup_freq", cal_freq, 32'h000F_4240);
    wait_idle();
    $display("test powerup done");
    code = 8'(($urandom % 254) + 1);
    fail_next <= 1'b1;
    code_next <= code;
    dly <= 32'(3 + $urandom % 6);
    b0 = beeps;
    fire(P_FORCE);
    wait_start(8, n);
    chk_true("force_start", n <= 3);
    wait_idle();
    check("err_show", {31'h0, err_show}, 32'h1);
    check("err_code", {24'h0, err_code}, {24'h0, code});
    repeat (3) @(posedge core_clk);
    check("beep_cycles", 32'(beeps - b0), 32'h1);
    fail_next <= 1'b0;
    $display("test failure done");
    for (int i = 0; i < 4; i++) begin
      tuned_freq <= (i == 0) ? MIN_CAL_FREQ_HZ :
                    MIN_CAL_FREQ_HZ + 32'($urandom % 10_000_000);
      param_remote <= (i < 3);
      manual_mode <= (i == 3);
      fire(P_CHG);
      wait_start(8, n);
      check("prompt_start", 32'(n), 32'h2);
      check("cal_freq", cal_freq, tuned_freq);
      wait_idle();
    end
    param_remote <= 1'b0;
    manual_mode <= 1'b0;
    fire(P_CHG);
    wait_start(DL + 10, n);
    chk_true("front_delay", n >= DL && n <= DL + 6);
    wait_idle();
    $display("test parameter timing done");
    tuned_freq <= MIN_CAL_FREQ_HZ - 32'h1;
    param_remote <= 1'b1;
    fire(P_CHG);
    quiet(DL + 10, "low_freq_none");
    tuned_freq <= 32'h0098_9680;
    param_remote <= 1'b0;
    param_knob <= 1'b1;
    fire(P_CHG);
    quiet(DL + 10, "knob_none");
    param_knob <= 1'b0;
    tuned_freq <= 32'h0000_0014;
    fire(P_FORCE);
    wait_start(8, n);
    check("low_cal_freq", cal_freq, MIN_CAL_FREQ_HZ);
    wait_idle();
    $display("test suppression done");
    tuned_freq <= 32'h0098_9680;
    dly <= 32'h0000_0064;
    fire(P_FORCE);
    wait_start(8, n);
    fire(P_ENTRY);
    #1;
    check("refused", {30'h0, remote_refused, remote_accept}, 32'h2);
    fire(P_CHG);
    wait_start(1, n);
    n = 0;
    while (cal_abort !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("abort_pulse", {31'h0, cal_abort}, 32'h1);
    check("abort_run", {25'h0, run_vec}, 32'h0);
    dly <= 32'h0000_0005;
    wait_start(DL + 10, n);
    chk_true("restart_delay", n >= DL - 3 && n <= DL + 6);
    wait_idle();
    fire(P_ENTRY);
    #1;
    check("accepted", {30'h0, remote_refused, remote_accept}, 32'h1);
    $display("test abort and entry done");
    fire(P_REM);
    wait_start(8, n);
    chk_true("remote_preset", n <= 3);
    wait_idle();
    fire(P_FRONT);
    wait_start(DL + 10, n);
    chk_true("front_preset", n >= DL && n <= DL + 6);
    wait_idle();
    $display("test presets done");
    quiet(PD - 10, "period_restart");
    noise_busy <= 1'b1;
    quiet(30, "noise_hold");
    noise_busy <= 1'b0;
    sweep_active <= 1'b1;
    sweep_time_ms <= LONG_SWEEP_MS - 32'h1;
    quiet(10, "short_sweep_hold");
    sweep_time_ms <= LONG_SWEEP_MS;
    wait_start(6, n);
    chk_true("long_sweep_start", n < 6);
    sweep_active <= 1'b0;
    wait_idle();
    $display("test periodic done");
    fire(P_FORCE);
    wait_start(8, n);
    wait_idle();
    fire(P_DIS);
    s0 = starts;
    n = 0;
    while (cal_disabled_ind !== 1'b1 && n < PD + 10) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk_true("disabled_ind", cal_disabled_ind === 1'b1);
    check("disabled_none", 32'(starts), 32'(s0));
    param_remote <= 1'b1;
    repeat (3) fire(P_CHG);
    quiet(10, "burst_none");
    fire(P_EN);
    wait_start(8, n);
    chk_true("enable_start", n < 8);
    check("ind_clear", {31'h0, cal_disabled_ind}, 32'h0);
    wait_idle();
    $display("test disable done");
    print_verdict();
  end
endmodule
